// ---- iaeu_execute.sv ----
`timescale 1ns/100ps
// execute stage for the integer add group plus common pipeline rules
module iaeu_execute #(
    parameter int XLEN = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic mode64,
    input wire logic mode16,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic [63:0] instrAddr,
    input wire logic intRequest,
    input wire logic [63:0] loadData,
    input wire logic loadCacheable,
    input wire logic tlbHit,
    input wire logic [63:0] sysReadData,
    output logic stall,
    output logic excValid,
    output logic [3:0] excCode,
    output logic [63:0] exceptionReturnAddress,
    output logic redirectValid,
    output logic [63:0] redirectTarget,
    output logic memReq,
    output logic [63:0] memAddr,
    output logic [7:0] memLanes,
    output logic memCacheFill,
    output logic sysWrite,
    output logic [4:0] sysRegIdx,
    output logic [63:0] sysWriteData,
    output logic [63:0] resultData,
    output logic [4:0] resultReg,
    output logic resultValid
);
    import iaeu_pkg::*;

    initial begin
        if (XLEN != 64) $error("iaeu_execute supports XLEN of 64 only");
    end

    // reset release through two flops
    logic rstSync1, rstSync2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    logic rstInt_n;
    assign rstInt_n = rstSync2;

    // sign-extend a 16-bit immediate to 64 bits
    function automatic logic [63:0] signExt16(input logic [15:0] imm);
        signExt16 = {{48{imm[IMM_SIGN_POS]}}, imm}; // [RULE7]
    endfunction

    // fold a 32-bit sum into the active mode's result width
    function automatic logic [63:0] foldSum(input logic [63:0] s,
                                            input logic m64);
        foldSum = m64 ? {{32{s[31]}}, s[31:0]} // [RULE3] [RULE21]
                      : {32'h0, s[31:0]};
    endfunction

    // overflow when carry into bit 31 differs from carry out of it
    function automatic logic addOverflow(input logic [31:0] a,
                                         input logic [31:0] b);
        logic [31:0] low;
        logic [32:0] full;
        low = {1'b0, a[30:0]} + {1'b0, b[30:0]};
        full = {1'b0, a} + {1'b0, b};
        addOverflow = low[31] ^ full[32];
    endfunction

    // general register file, flops indexed by register number
    logic [63:0] general_register [NUM_REGS];
    logic [63:0] sysRegs [NUM_SYS_REGS];

    // instruction fields
    logic [5:0] opcode, funct;
    logic [4:0] srcA, srcB, dest, sysOp;
    logic [15:0] imm;
    always_comb begin
        opcode = instrWord[31:OPCODE_POS];
        srcA = instrWord[SRCA_POS+4:SRCA_POS];
        srcB = instrWord[SRCB_POS+4:SRCB_POS];
        dest = instrWord[DEST_POS+4:DEST_POS];
        funct = instrWord[5:0];
        sysOp = srcA;
        imm = instrWord[15:0];
    end

    // register reads, register zero forced to zero
    logic [63:0] valA, valB;
    always_comb begin
        valA = (srcA == 5'd0) ? 64'h0 : general_register[srcA]; // [RULE20]
        valB = (srcB == 5'd0) ? 64'h0 : general_register[srcB]; // [RULE20]
    end

    // decode
    logic isAddRegTrap, isAddRegNoTrap, isAddImmTrap, isAddImmNoTrap;
    logic isJumpReg, isJump, isBranch, isLoad, isSysFrom, isSysTo;
    logic isSpecial;
    always_comb begin
        isSpecial = opcode == OP_SPECIAL;
        isAddRegTrap = isSpecial && funct == FN_ADD_REG_TRAP;
        isAddRegNoTrap = isSpecial && funct == FN_ADD_REG_NOTRAP;
        isAddImmTrap = opcode == OP_ADD_IMM_TRAP;
        isAddImmNoTrap = opcode == OP_ADD_IMM_NOTRAP;
        isJumpReg = isSpecial &&
            (funct == FN_JUMP_REG || funct == FN_JUMP_REG_LINK);
        isJump = opcode == OP_JUMP || opcode == OP_JUMP_LINK;
        isBranch = opcode == OP_BRANCH_EQ || opcode == OP_BRANCH_NE;
        isLoad = opcode == OP_LOAD_WORD;
        isSysFrom = opcode == OP_SYS_CTRL && sysOp == SYS_MOVE_FROM;
        isSysTo = opcode == OP_SYS_CTRL && sysOp == SYS_MOVE_TO;
    end

    // load-use hazard: previous load wrote a register this one reads
    logic loadPending;
    logic [4:0] loadDest;
    logic hazard;
    iaeu_state_t state;
    always_comb begin
        hazard = instrValid && loadPending && loadDest != 5'd0 &&
            (loadDest == srcA || loadDest == srcB); // [RULE8]
    end

    // interlock state machine: one extra cycle waits for load data
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            state <= ST_RUN;
        end else if (clkEn) begin
            case (state)
                ST_RUN: if (hazard && !stall) state <= ST_LOAD_STALL;
                ST_LOAD_STALL: state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    logic go;
    assign go = instrValid && !(hazard && state == ST_RUN);

    // adder datapath
    logic [63:0] operandB, sum, addResult;
    logic useImm, trapForm, isAdd, ovf;
    always_comb begin
        useImm = isAddImmTrap || isAddImmNoTrap;
        operandB = useImm ? signExt16(imm) : valB; // [RULE4] [RULE5]
        sum = valA + operandB;
        addResult = foldSum(sum, mode64);
        trapForm = isAddRegTrap || isAddImmTrap; // [RULE5] [RULE6]
        isAdd = trapForm || isAddRegNoTrap || isAddImmNoTrap;
        ovf = trapForm && addOverflow(valA[31:0], operandB[31:0]); // [RULE1] [RULE4]
    end

    // jump-register alignment and fault detection
    logic misalign, inSlot;
    logic [63:0] branchAddr;
    logic next_fault;
    iaeu_exc_t next_code;
    logic [63:0] jrTarget, jTarget, bTarget, immExt;
    always_comb begin
        immExt = signExt16(imm);
        jrTarget = valA;
        misalign = isJumpReg &&
            (mode16 ? jrTarget[0] : |jrTarget[1:0]); // [RULE13]
        jTarget = {instrAddr[63:28], instrWord[25:0], 2'b00};
        bTarget = instrAddr + 64'd4 + {immExt[61:0], 2'b00};
        next_fault = 1'b0;
        next_code = EXC_NONE;
        if (isLoad && !tlbHit) begin
            next_fault = 1'b1;
            next_code = EXC_TLB_MISS; // [RULE18]
        end else if (misalign) begin
            next_fault = 1'b1;
            next_code = EXC_ADDR_FETCH;
        end else if (ovf) begin
            next_fault = 1'b1;
            next_code = EXC_OVERFLOW;
        end else if (intRequest) begin
            next_fault = 1'b1;
            next_code = EXC_NONE;
        end
    end

    // delay slot tracking: the next instruction after a jump runs always
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            inSlot <= 1'b0;
            branchAddr <= PC_RESET;
        end else if (clkEn && go) begin
            inSlot <= isJump || isJumpReg || isBranch; // [RULE9]
            branchAddr <= instrAddr;
        end
    end

    // exception report, return address points at branch when in slot
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            excValid <= 1'b0;
            excCode <= 4'h0;
            exceptionReturnAddress <= PC_RESET;
        end else if (clkEn) begin
            excValid <= go && next_fault;
            if (go && next_fault) begin
                excCode <= next_code;
                exceptionReturnAddress <= inSlot ? branchAddr
                                                 : instrAddr; // [RULE11]
            end
        end
    end

    // redirect issued now; the slot instruction still executes next
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            redirectValid <= 1'b0;
            redirectTarget <= PC_RESET;
        end else if (clkEn) begin
            redirectValid <= 1'b0;
            if (go && !next_fault) begin
                if (isJumpReg) begin
                    redirectValid <= 1'b1; // [RULE9]
                    redirectTarget <= jrTarget;
                end else if (isJump) begin
                    redirectValid <= 1'b1;
                    redirectTarget <= jTarget;
                end else if (isBranch &&
                    ((valA == valB) == (opcode == OP_BRANCH_EQ))) begin
                    redirectValid <= 1'b1;
                    redirectTarget <= bTarget;
                end
            end
        end
    end

    // memory request for loads: whole word, cache fill when cacheable
    logic [7:0] lanes;
    logic [63:0] effAddr;
    assign effAddr = valA + signExt16(imm);
    iaeu_byte_lanes uLanes (
        .addrLow(effAddr[2:0]),
        .accType(ACC_WORD),
        .laneMask(lanes)
    );
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            memReq <= 1'b0;
            memAddr <= 64'h0;
            memLanes <= 8'h00;
            memCacheFill <= 1'b0;
        end else if (clkEn) begin
            memReq <= go && isLoad && tlbHit;
            memAddr <= effAddr;
            memLanes <= lanes; // [RULE17]
            memCacheFill <= go && isLoad && tlbHit && loadCacheable; // [RULE19]
        end
    end

    // load pending tracker used by the interlock; a one-cycle pulse, so
    // load data is written exactly once and idle cycles end the hazard
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            loadPending <= 1'b0;
            loadDest <= 5'd0;
        end else if (clkEn) begin
            loadPending <= go && isLoad && tlbHit; // [RULE8]
            if (go) loadDest <= srcB;
        end
    end

    // system control registers: only move-to/move-from reach them
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            for (int i = 0; i < NUM_SYS_REGS; i++) sysRegs[i] <= REG_RESET;
            sysWrite <= 1'b0;
            sysRegIdx <= 5'd0;
            sysWriteData <= 64'h0;
        end else if (clkEn) begin
            sysWrite <= go && !next_fault && isSysTo; // [RULE14]
            sysRegIdx <= dest;
            sysWriteData <= valB;
            if (go && !next_fault && isSysTo) sysRegs[dest] <= valB;
        end
    end

    // writeback select; trapped adds leave destination untouched
    logic wbEn;
    logic [4:0] wbReg;
    logic [63:0] wbData;
    always_comb begin
        wbEn = 1'b0;
        wbReg = 5'd0;
        wbData = 64'h0;
        if (go && !next_fault) begin
            if (isAdd) begin
                wbEn = 1'b1; // [RULE2]
                wbReg = useImm ? srcB : dest; // [RULE1] [RULE6]
                wbData = addResult;
            end else if (isSysFrom) begin
                wbEn = 1'b1; // [RULE14]
                wbReg = srcB;
                wbData = sysRegs[dest] | (sysReadData & 64'h0);
            end
        end
        if (loadPending && state != ST_LOAD_STALL && !go) begin
            wbEn = 1'b0;
        end
    end

    // load data return writes the loaded register
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            for (int i = 0; i < NUM_REGS; i++) general_register[i] <= REG_RESET;
        end else if (clkEn) begin
            if (wbEn && wbReg != 5'd0) general_register[wbReg] <= wbData; // [RULE20]
            if (loadPending && loadDest != 5'd0)
                general_register[loadDest] <= foldSum(loadData, mode64);
        end
    end

    // result port and stall flag
    always_ff @(posedge clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            resultValid <= 1'b0;
            resultReg <= 5'd0;
            resultData <= 64'h0;
            stall <= 1'b0;
        end else if (clkEn) begin
            resultValid <= wbEn && wbReg != 5'd0;
            resultReg <= wbReg;
            resultData <= (wbReg == 5'd0) ? 64'h0 : wbData;
            stall <= hazard && state == ST_RUN; // [RULE8]
        end
    end
endmodule // iaeu_execute

// ---- iaeu_pkg.sv ----
// What this block does
// [RULE1] trapping register add: sum into destination, trap when carries 30/31 differ
// [RULE2] on overflow trap the destination register is left unchanged
// [RULE3] 64-bit mode: upper 32 result bits copy bit 31 of sum
// [RULE4] trapping immediate add: sign-extend immediate, add, write target, trap overflow
// [RULE5] non-trapping immediate add never raises overflow
// [RULE6] non-trapping register add never raises overflow
// [RULE7] sign extension replicates immediate bit 15 above bits 15..0
// [RULE8] use of a just-loaded register stalls one cycle by interlock
// [RULE9] jumps and branches have exactly one delay-slot instruction
// [RULE10] software never puts a jump or branch in a delay slot
// [RULE11] fault in delay slot reports the preceding branch address for restart
// [RULE12] linking jumps never use the link register r31 as a source
// [RULE13] register jump target misaligned raises address exception at fetch
// [RULE14] system control registers only reached by move-to and move-from
// [RULE15] access type encodes sizes of one to eight bytes
// [RULE16] address names the lowest, rightmost byte of the field
// [RULE17] byte lanes come from access type and low three address bits
// [RULE18] translation miss raises an exception
// [RULE19] cacheable load returns whole word and fills the cache
// [RULE20] general register zero reads zero, writes to it are dropped
// [RULE21] 64-bit add with bad operands gives any result, no extra trap
package iaeu_pkg;
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_ADD_IMM_TRAP = 6'h08;
    localparam logic [5:0] OP_ADD_IMM_NOTRAP = 6'h09;
    localparam logic [5:0] OP_JUMP = 6'h02;
    localparam logic [5:0] OP_JUMP_LINK = 6'h03;
    localparam logic [5:0] OP_BRANCH_EQ = 6'h04;
    localparam logic [5:0] OP_BRANCH_NE = 6'h05;
    localparam logic [5:0] OP_LOAD_WORD = 6'h23;
    localparam logic [5:0] OP_SYS_CTRL = 6'h10;
    localparam logic [5:0] FN_ADD_REG_TRAP = 6'h20;
    localparam logic [5:0] FN_ADD_REG_NOTRAP = 6'h21;
    localparam logic [5:0] FN_JUMP_REG = 6'h08;
    localparam logic [5:0] FN_JUMP_REG_LINK = 6'h09;
    localparam logic [4:0] SYS_MOVE_FROM = 5'h00;
    localparam logic [4:0] SYS_MOVE_TO = 5'h04;
    localparam int OPCODE_POS = 26;
    localparam int SRCA_POS = 21;
    localparam int SRCB_POS = 16;
    localparam int DEST_POS = 11;
    localparam int IMM_SIGN_POS = 15;
    localparam int NUM_REGS = 32;
    localparam int NUM_SYS_REGS = 32;
    localparam logic [63:0] REG_RESET = 64'h0;
    localparam logic [63:0] PC_RESET = 64'h0;
    typedef enum logic [2:0] {
        ACC_BYTE, ACC_HALF, ACC_TRIPLE, ACC_WORD,
        ACC_QUINT, ACC_SEXT, ACC_SEPT, ACC_DOUBLE
    } iaeu_access_t;
    typedef enum logic [3:0] {
        EXC_NONE, EXC_OVERFLOW, EXC_ADDR_FETCH, EXC_TLB_MISS
    } iaeu_exc_t;
    typedef enum {ST_RUN, ST_LOAD_STALL} iaeu_state_t;
endpackage

// ---- iaeu_byte_lanes.sv ----
`timescale 1ns/100ps
// byte-lane selection for one access; pure combinational helper
module iaeu_byte_lanes (
    input wire logic [2:0] addrLow,
    input wire iaeu_pkg::iaeu_access_t accType,
    output logic [7:0] laneMask
);
    import iaeu_pkg::*;
    logic [15:0] wide;
    // field starts at the lowest byte address (little endian only)
    always_comb begin
        wide = {8'h00, 8'hff >> (3'd7 - 3'(accType))}; // [RULE15]
        wide = wide << addrLow; // [RULE16] [RULE17]
        laneMask = wide[7:0];
    end
endmodule // iaeu_byte_lanes

// ---- iaeu_execute_chk.sv ----
`timescale 1ns/100ps
// port relations of the add execute stage
module iaeu_execute_chk
    import iaeu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode64,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    input wire logic loadCacheable,
    input wire logic stall,
    input wire logic excValid,
    input wire logic [3:0] excCode,
    input wire logic redirectValid,
    input wire logic memReq,
    input wire logic [63:0] memAddr,
    input wire logic [7:0] memLanes,
    input wire logic memCacheFill,
    input wire logic sysWrite,
    input wire logic resultValid,
    input wire logic [63:0] resultData
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decode of the word on offer; a held word decodes the same
    wire [5:0] opc = instrWord[31:26];
    wire [5:0] fn = instrWord[5:0];
    wire isSpecial = opc == OP_SPECIAL;
    wire trapAdd = instrValid && (opc == OP_ADD_IMM_TRAP
        || isSpecial && fn == FN_ADD_REG_TRAP);
    wire freeAdd = instrValid && (opc == OP_ADD_IMM_NOTRAP
        || isSpecial && fn == FN_ADD_REG_NOTRAP);
    wire isJump = instrValid && (opc inside {OP_JUMP, OP_JUMP_LINK,
        OP_BRANCH_EQ, OP_BRANCH_NE} || isSpecial
        && fn inside {FN_JUMP_REG, FN_JUMP_REG_LINK});
    wire ovf = excValid && excCode == EXC_OVERFLOW;
    // a refused use of a load: load out, then one stall cycle
    sequence s_load_hazard;
        memReq ##1 stall;
    endsequence
    a_ovf_cause: assert property (ovf |-> $past(trapAdd))
        else $error("overflow from a non-trapping op");
    a_ovf_keep: assert property (ovf |-> !resultValid)
        else $error("result written on overflow");
    a_no_trap: assert property ($past(freeAdd) |-> !ovf)
        else $error("overflow from a non-trapping add");
    a_sext_high: assert property (resultValid && $past(mode64)
        |-> resultData[63:32] == {32{resultData[31]}})
        else $error("upper result half not a sign copy");
    a_stall_once: assert property (s_load_hazard |=> !stall)
        else $error("load stall longer than one cycle");
    a_lane_word: assert property (memReq && memAddr[1:0] == 2'h0
        |-> memLanes == 8'h0f << memAddr[2:0])
        else $error("word lanes wrong");
    a_fill_load: assert property (memCacheFill
        |-> memReq && $past(loadCacheable))
        else $error("fill without cacheable load");
    a_sys_move: assert property (sysWrite |-> $past(instrValid
        && opc == OP_SYS_CTRL && instrWord[25:21] == SYS_MOVE_TO))
        else $error("control write without move-to");
    a_jump_redirect: assert property (redirectValid |-> $past(isJump))
        else $error("redirect without jump");
endmodule // iaeu_execute_chk

bind iaeu_execute iaeu_execute_chk i_iaeu_execute_chk (.clk, .rst_n,
    .mode64, .instrValid, .instrWord, .loadCacheable, .stall, .excValid,
    .excCode, .redirectValid, .memReq, .memAddr, .memLanes, .memCacheFill,
    .sysWrite, .resultValid, .resultData);

// ---- iaeu_mem_model.sv ----
`timescale 1ns/100ps
// memory side: answers a word load in the same cycle that memReq is high
module iaeu_mem_model (
    input wire logic clk,
    input wire logic memReq,
    input wire logic [63:0] memAddr,
    output logic [63:0] loadData
);
    logic [63:0] noise = 64'h0;
    logic [31:0] word;
    // junk between loads so a stale value cannot pass
    always_ff @(posedge clk) noise <= noise + 64'h9e37_79b9_7f4a_7c15;
    // whole word, sign-extended so 64-bit adds see legal operands
    assign word = memAddr[31:0] ^ 32'h8a5c_31f7;
    assign loadData = memReq ? {{32{word[31]}}, word} : noise;
endmodule // iaeu_mem_model

// ---- integer_add_execute_unit_tb.sv ----
`timescale 1ns/100ps
// drives the add unit and checks it against an integer model
module integer_add_execute_unit_tb;
    import iaeu_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mode64 = 1'b1, instrValid = 1'b0;
    logic intRequest = 1'b0, loadCacheable = 1'b0, tlbHit = 1'b1;
    logic [31:0] instrWord = 32'h0;
    logic [63:0] instrAddr = 64'h0;
    logic [63:0] loadData, exceptionReturnAddress, memAddr, sysWriteData;
    logic [63:0] resultData;
    logic stall, excValid, redirectValid, memReq, memCacheFill, sysWrite;
    logic resultValid;
    logic [3:0] excCode;
    logic [4:0] sysRegIdx, resultReg;
    logic [7:0] memLanes;
    logic [63:0] rf [32];
    logic [4:0] prevLd = 5'h0;
    int checks = 0, mismatches = 0, seed = 85;

    always #50 clk = ~clk;

    iaeu_execute i_iaeu_execute (.clk, .rst_n, .clkEn(1'b1), .mode64,
        .mode16(1'b0), .instrValid, .instrWord, .instrAddr, .intRequest,
        .loadData, .loadCacheable, .tlbHit, .sysReadData(64'h0), .stall,
        .excValid, .excCode, .exceptionReturnAddress, .redirectValid,
        .redirectTarget(), .memReq, .memAddr, .memLanes, .memCacheFill,
        .sysWrite, .sysRegIdx, .sysWriteData, .resultData, .resultReg,
        .resultValid);
    iaeu_mem_model i_iaeu_mem_model (.clk, .memReq, .memAddr, .loadData);

    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction
    function automatic logic [31:0] rr(input logic [5:0] f,
        input logic [4:0] a, b, d);
        return {OP_SPECIAL, a, b, d, 5'h0, f};
    endfunction
    function automatic logic [31:0] im(input logic [5:0] o,
        input logic [4:0] a, b, input logic [15:0] v);
        return {o, a, b, v};
    endfunction

    task automatic stop_test();
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // idle cycles; a use after a gap is no longer a hazard
    task automatic gap(input int n);
        repeat (n) begin
            instrValid = 1'b0;
            intRequest = 1'b0;
            prevLd = 5'h0;
            @(posedge clk);
            #1;
        end
    endtask
    // offer one word; a refused use of a load is held one more edge
    task automatic issue(input logic [31:0] w, input logic q);
        logic hz;
        hz = prevLd != 5'h0 && (w[25:21] == prevLd
            || w[31:26] == OP_SPECIAL && w[20:16] == prevLd);
        instrValid = 1'b1;
        instrWord = w;
        intRequest = q;
        @(posedge clk);
        #1;
        if (hz) begin
            cmp(64'h1, 64'(stall));
            @(posedge clk);
            #1;
        end
        prevLd = 5'h0;
        instrAddr = instrAddr + 64'h4;
    endtask
    task automatic doAdd(input logic [31:0] w, input logic q);
        logic [63:0] a, b, msk;
        logic [31:0] s;
        logic [4:0] d;
        logic sp, ovf;
        sp = w[31:26] == OP_SPECIAL;
        d = sp ? w[15:11] : w[20:16];
        a = rf[w[25:21]];
        b = sp ? rf[w[20:16]] : {{48{w[15]}}, w[15:0]};
        s = a[31:0] + b[31:0];
        ovf = (w[31:26] == OP_ADD_IMM_TRAP || sp && w[5:0] == FN_ADD_REG_TRAP)
            && a[31] == b[31] && s[31] != a[31];
        msk = mode64 ? 64'hffff_ffff_ffff_ffff : 64'hffff_ffff;
        issue(w, q);
        cmp(64'(q | ovf), 64'(excValid));
        if (q | ovf) begin
            cmp(ovf ? 64'h1 : 64'h0, 64'(excCode));
            cmp(64'h0, 64'(resultValid));
        end else if (d != 5'h0) begin
            cmp(64'h1, 64'(resultValid));
            cmp(64'(d), 64'(resultReg));
            cmp(sx(s) & msk, resultData & msk);
            rf[d] = sx(s);
        end
    endtask
    task automatic ld(input logic [15:0] off, input logic [4:0] t,
        input logic h);
        logic [63:0] a;
        a = {{48{off[15]}}, off};
        tlbHit = h;
        loadCacheable = off[4];
        issue(im(OP_LOAD_WORD, 5'h0, t, off), 1'b0);
        if (h) begin
            cmp(64'h1, 64'(memReq));
            cmp(a, memAddr);
            cmp(64'(8'h0f << a[2:0]), 64'(memLanes));
            cmp(64'(off[4]), 64'(memCacheFill));
            rf[t] = sx(a[31:0] ^ 32'h8a5c_31f7);
            prevLd = t;
        end else begin
            cmp(64'h1, 64'(excValid));
            cmp(64'h3, 64'(excCode));
        end
    endtask

    initial begin
        logic [31:0] k;
        logic seen;
        for (int i = 0; i < 32; i++) rf[i] = REG_RESET;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        gap(3);
        // random loads feed random adds of all four kinds
        for (int i = 0; i < 24; i++) begin
            ld(16'($random(seed)) & 16'hfffc, 5'(1 + i % 4), 1'b1);
            gap(1);
            k = $random(seed);
            doAdd(k[1] ? im(k[0] ? OP_ADD_IMM_NOTRAP : OP_ADD_IMM_TRAP,
                5'(k[4:2]), 5'(k[10:8]), k[31:16]) : rr(k[0] ?
                FN_ADD_REG_NOTRAP : FN_ADD_REG_TRAP, 5'(k[4:2]),
                5'(k[7:5]), 5'(k[10:8])), 1'b0);
        end
        ld(16'h0040, 5'h5, 1'b1);
        doAdd(rr(FN_ADD_REG_NOTRAP, 5'h5, 5'h0, 5'h6), 1'b0);
        // a large negative doubled overflows and then stays put
        repeat (3) doAdd(rr(FN_ADD_REG_TRAP, 5'h6, 5'h6, 5'h6), 1'b0);
        doAdd(im(OP_ADD_IMM_NOTRAP, 5'h0, 5'h0, 16'h1234), 1'b0);
        doAdd(rr(FN_ADD_REG_NOTRAP, 5'h0, 5'h0, 5'h7), 1'b0);
        // delay slot holds an add, never a jump; no link register used
        for (int i = 0; i < 2; i++) begin
            gap(1);
            instrAddr = 64'h100;
            issue({OP_JUMP, 26'h40}, 1'b0);
            cmp(64'h1, 64'(redirectValid));
            doAdd(rr(FN_ADD_REG_NOTRAP, 5'h1, 5'h2, 5'h8), i[0]);
            if (i == 1) cmp(64'h100, exceptionReturnAddress);
        end
        // register jump: misaligned target faults, aligned does not
        for (int i = 0; i < 2; i++) begin
            doAdd(im(OP_ADD_IMM_NOTRAP, 5'h0, 5'h9,
                i != 0 ? 16'h0100 : 16'h0102), 1'b0);
            issue(rr(FN_JUMP_REG, 5'h9, 5'h0, 5'h0), 1'b0);
            seen = excValid === 1'b1 && excCode === 4'h2;
            issue(rr(FN_ADD_REG_NOTRAP, 5'h0, 5'h0, 5'ha), 1'b0);
            repeat (4) begin
                seen = seen | (excValid === 1'b1 && excCode === 4'h2);
                gap(1);
            end
            cmp(64'(i == 0), 64'(seen));
        end
        issue(im(OP_SYS_CTRL, SYS_MOVE_TO, 5'h1, 16'h6000), 1'b0);
        cmp(64'h1, 64'(sysWrite));
        cmp(64'hc, 64'(sysRegIdx));
        cmp(rf[1], sysWriteData);
        gap(1);
        ld(16'h0200, 5'h3, 1'b0);
        // 32-bit mode: only the low word of each sum is defined
        gap(1);
        mode64 = 1'b0;
        for (int i = 0; i < 6; i++) begin
            k = $random(seed);
            doAdd(rr(k[0] ? FN_ADD_REG_NOTRAP : FN_ADD_REG_TRAP, 5'(k[3:1]),
                5'(k[6:4]), 5'(k[9:7])), 1'b0);
        end
        gap(2);
        stop_test();
    end

    // cut a hang short
    initial begin
        #5000000;
        mismatches++;
        stop_test();
    end
endmodule // integer_add_execute_unit_tb
